// ===== include/pp_port_map.vh
// register offsets, field positions, reset values and timing counts
// of the printer port slave registers.
// assumes byte-wide host accesses with a 12-bit offset in the 4K block.
`ifndef PP_PORT_MAP_VH
`define PP_PORT_MAP_VH

// ----------------------------------------------------------------
// register byte offsets within the slave block
// ----------------------------------------------------------------
`define PP_OFS_DIRECTED_RESET 12'h000
`define PP_OFS_DATA 12'h800
`define PP_OFS_LINE_STATUS 12'h801
`define PP_OFS_DEVICE_CONTROL 12'h802
`define PP_OFS_UNUSED 12'h803
`define PP_OFS_MODE_CONTROL 12'h804
`define PP_OFS_IRQ_ENABLE 12'h805
`define PP_OFS_LEGACY_DELAY 12'h806
`define PP_OFS_PULSE_DELAY 12'h807

// ----------------------------------------------------------------
// device control fields
// ----------------------------------------------------------------
`define PP_DC_DIRECTION 5
`define PP_DC_LEGACY_IRQ 4
`define PP_DC_SELECT_IN 3
`define PP_DC_INIT 2
`define PP_DC_AUTO_FEED 1
`define PP_DC_STROBE 0
// strobe high, auto-feed high, init low, select-in low, output direction
`define PP_DC_RESET 6'h00

// ----------------------------------------------------------------
// mode control fields
// ----------------------------------------------------------------
`define PP_MC_MODE_HI 7
`define PP_MC_MODE_LO 5
`define PP_MC_BIDIR_EN 4
`define PP_MC_FORCE_PULSE 3
`define PP_MODE_SOFTWARE 3'h0
`define PP_MODE_ACK_BUSY 3'h1
`define PP_MODE_BUSY_ONLY 3'h2
`define PP_MODE_RESERVED 3'h3
`define PP_MODE_STREAM 3'h4
`define PP_MC_RESET 5'h00

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define PP_IRQ_EN_RESET 8'h00
`define PP_LEGACY_DELAY_RESET 8'h00
`define PP_CLK_PERIOD_NS 4
`define PP_PULSE_DELAY_NS 1000
// one microsecond in clock cycles, rounded up
`define PP_PULSE_DELAY_CYC \
	((`PP_PULSE_DELAY_NS + `PP_CLK_PERIOD_NS - 1) / `PP_CLK_PERIOD_NS)

`endif

// ===== src/pp_strobe_engine.v
// automatic strobe sequencer: setup, optional busy wait, low pulse, hold.
// assumes busy already synchronised and start only while idle.
`timescale 1ns/1ns
`default_nettype none

module pp_strobe_engine (
	// clock and reset
	input wire clk_in,
	input wire rst_n_in,
	input wire soft_clr_in,
	// control
	input wire start_in,
	input wire wait_busy_in,
	input wire busy_in,
	input wire [7:0] delay_in,
	// status
	output reg strobe_low_out,
	output reg active_out
);

	// ----------------------------------------------------------------
	// states and counters
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SETUP = 3'h1;
	localparam [2:0] ST_WAIT = 3'h2;
	localparam [2:0] ST_PULSE = 3'h3;
	localparam [2:0] ST_HOLD = 3'h4;

	reg [2:0] state_q; // sequencer state
	reg [7:0] count_q; // cycles left in phase
	reg wait_q; // busy wait wanted for this byte
	wire [7:0] load_w; // phase length, never zero

	// a zero delay still gives one cycle per phase
	assign load_w = (delay_in == 8'h00) ? 8'h01 : delay_in;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
			count_q <= 8'h00;
			wait_q <= 1'b0;
			strobe_low_out <= 1'b0;
			active_out <= 1'b0;
		end else if (soft_clr_in) begin
			// directed reset aborts any transfer
			state_q <= ST_IDLE;
			count_q <= 8'h00;
			wait_q <= 1'b0;
			strobe_low_out <= 1'b0;
			active_out <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				strobe_low_out <= 1'b0;
				if (start_in) begin
					state_q <= ST_SETUP;
					count_q <= load_w;
					wait_q <= wait_busy_in;
					active_out <= 1'b1;
				end
			end
			ST_SETUP: begin
				// data setup before the strobe falls
				if (count_q == 8'h01) begin
					state_q <= wait_q ? ST_WAIT : ST_PULSE;
					strobe_low_out <= !wait_q;
					count_q <= load_w;
				end else begin
					count_q <= count_q - 8'h01;
				end
			end
			ST_WAIT: begin
				// printer must not be busy before strobing
				if (!busy_in) begin
					state_q <= ST_PULSE;
					strobe_low_out <= 1'b1;
				end
			end
			ST_PULSE: begin
				if (count_q == 8'h01) begin
					state_q <= ST_HOLD;
					strobe_low_out <= 1'b0;
					count_q <= load_w;
				end else begin
					count_q <= count_q - 8'h01;
				end
			end
			ST_HOLD: begin
				// data hold after the strobe rises
				if (count_q == 8'h01) begin
					state_q <= ST_IDLE;
					active_out <= 1'b0;
				end else begin
					count_q <= count_q - 8'h01;
				end
			end
			default: begin
				state_q <= ST_IDLE;
				strobe_low_out <= 1'b0;
				active_out <= 1'b0;
			end
			endcase
		end
	end

endmodule

`default_nettype wire

// ===== src/pp_port_slave.v
// printer port slave registers: host byte port, data path, status and
// control lines, directed reset and strobe selection by mode.
// assumes a byte-wide host port on clk_in and connector lines that are
// asynchronous to it; handshake detail beyond the strobe is elsewhere.
//
// Contract
// - register write resets port, keeps four lines
// - data write drives lines when output direction
// - data read returns lines; input needs both bits
// - data writes ignored during dma, reads work
// - status bits show busy inverted, ack, paper, select, fault
// - control bits 7,6 read one, writes ignored
// - direction bit counts only with bidirectional enable
// - legacy interrupt enable ignored, reads zero
// - automatic modes never touch the control bits
// - auto modes idle strobe high; mode 0 follows
// - legacy delay kept; pulse delay times strobe
// - power-up resets state, lines, enables, delay
// - mode bits select handshake; 3, 5-7 act as mode 0
`timescale 1ns/1ns
`default_nettype none
`include "pp_port_map.vh"

module pp_port_slave (
	// clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// host byte port
	input wire [11:0] addr_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [7:0] wdata_in,
	output reg [7:0] rdata_out,
	// dma engine status
	input wire dma_busy_in,
	// connector data lines
	input wire [7:0] data_line_in,
	output reg [7:0] data_line_out,
	output reg data_line_oe_out,
	// connector control outputs and their sensed levels
	output reg strobe_n_out,
	output reg auto_feed_n_out,
	output reg init_n_out,
	output reg select_in_n_out,
	input wire strobe_n_sense_in,
	input wire auto_feed_n_sense_in,
	input wire init_n_sense_in,
	input wire select_in_n_sense_in,
	// connector status inputs
	input wire busy_in,
	input wire ack_n_in,
	input wire paper_empty_line_in,
	input wire select_in,
	input wire fault_n_in
);

	// ----------------------------------------------------------------
	// constants and declarations
	// ----------------------------------------------------------------
	localparam SYNC_W = 17; // connector inputs crossing in
	// one microsecond count, cut to the register width on purpose
	localparam integer DELAY_CYC = `PP_PULSE_DELAY_CYC;
	localparam [7:0] DELAY_RESET = DELAY_CYC[7:0];

	reg [SYNC_W-1:0] sync1_q; // first stage, read only by second
	reg [SYNC_W-1:0] sync2_q; // stable copies
	wire [SYNC_W-1:0] raw_w; // gathered connector inputs
	reg soft_rst_q; // one-cycle directed reset pulse
	reg [7:0] data_q; // byte to drive out
	reg [5:0] dev_ctl_q; // device control bits 5..0
	reg [4:0] mode_ctl_q; // mode bits, bidir enable, force pulse
	reg [7:0] irq_en_q; // interrupt enables
	reg [7:0] legacy_delay_q; // obsolete delay location
	reg [7:0] pulse_delay_q; // strobe phase length in cycles
	reg [7:0] rdata_d; // read mux
	wire [2:0] mode_w; // raw mode code
	wire auto_w; // automatic handshake selected
	wire input_dir_w; // port takes data from the printer
	wire wr_data_w; // accepted data register write
	wire eng_strobe_w; // engine pulls strobe low
	wire eng_active_w; // engine transfer in progress

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	assign raw_w = {fault_n_in, select_in, paper_empty_line_in, ack_n_in,
		busy_in, select_in_n_sense_in, init_n_sense_in,
		auto_feed_n_sense_in, strobe_n_sense_in, data_line_in};

	// two flops per line; directed reset leaves them running
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
			always @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= raw_w[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	assign mode_w = mode_ctl_q[4:2];
	// reserved code and 5..7 behave as software handshake
	assign auto_w = (mode_w == `PP_MODE_ACK_BUSY) ||
		(mode_w == `PP_MODE_BUSY_ONLY) ||
		(mode_w == `PP_MODE_STREAM);
	// direction bit matters only when bidir enable is set
	assign input_dir_w = mode_ctl_q[1] && dev_ctl_q[`PP_DC_DIRECTION];
	// dma owns the data register; a busy engine also refuses new bytes
	assign wr_data_w = wr_en_in && (addr_in == `PP_OFS_DATA) &&
		!dma_busy_in && !eng_active_w;

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			soft_rst_q <= 1'b0;
			data_q <= 8'h00;
			dev_ctl_q <= `PP_DC_RESET;
			mode_ctl_q <= `PP_MC_RESET;
			irq_en_q <= `PP_IRQ_EN_RESET;
			legacy_delay_q <= `PP_LEGACY_DELAY_RESET;
			pulse_delay_q <= DELAY_RESET;
		end else if (soft_rst_q) begin
			// same as power-up except the four line bits
			soft_rst_q <= 1'b0;
			data_q <= 8'h00;
			dev_ctl_q[`PP_DC_DIRECTION] <= 1'b0;
			dev_ctl_q[`PP_DC_LEGACY_IRQ] <= 1'b0;
			mode_ctl_q <= `PP_MC_RESET;
			irq_en_q <= `PP_IRQ_EN_RESET;
			legacy_delay_q <= `PP_LEGACY_DELAY_RESET;
			pulse_delay_q <= DELAY_RESET;
		end else begin
			// any value written starts the directed reset
			soft_rst_q <= wr_en_in &&
				(addr_in == `PP_OFS_DIRECTED_RESET);
			if (wr_data_w) begin
				data_q <= wdata_in;
			end
			// only host writes alter these bits, in any mode
			if (wr_en_in && (addr_in == `PP_OFS_DEVICE_CONTROL)) begin
				// bits 7,6 have no storage; legacy enable held at zero
				dev_ctl_q <= {wdata_in[5], 1'b0, wdata_in[3:0]};
			end
			if (wr_en_in && (addr_in == `PP_OFS_MODE_CONTROL)) begin
				mode_ctl_q <= wdata_in[7:3];
			end
			if (wr_en_in && (addr_in == `PP_OFS_IRQ_ENABLE)) begin
				irq_en_q <= wdata_in;
			end
			if (wr_en_in && (addr_in == `PP_OFS_LEGACY_DELAY)) begin
				legacy_delay_q <= wdata_in;
			end
			if (wr_en_in && (addr_in == `PP_OFS_PULSE_DELAY)) begin
				pulse_delay_q <= wdata_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// automatic strobe engine
	// ----------------------------------------------------------------
	pp_strobe_engine u_strobe (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.soft_clr_in(soft_rst_q),
		.start_in(wr_data_w && auto_w),
		.wait_busy_in((mode_w != `PP_MODE_STREAM) && !mode_ctl_q[0]),
		.busy_in(sync2_q[12]),
		.delay_in(pulse_delay_q),
		.strobe_low_out(eng_strobe_w),
		.active_out(eng_active_w)
	);

	// ----------------------------------------------------------------
	// connector outputs
	// ----------------------------------------------------------------
	// registered so every pin changes one cycle after its cause
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_line_out <= 8'h00;
			data_line_oe_out <= 1'b1;
			strobe_n_out <= 1'b1;
			auto_feed_n_out <= 1'b1;
			init_n_out <= 1'b0;
			select_in_n_out <= 1'b0;
		end else begin
			data_line_out <= data_q;
			data_line_oe_out <= !input_dir_w;
			if (auto_w) begin
				// idle high; only the engine pulls it low
				strobe_n_out <= !eng_strobe_w;
			end else begin
				strobe_n_out <= !dev_ctl_q[`PP_DC_STROBE];
			end
			auto_feed_n_out <= !dev_ctl_q[`PP_DC_AUTO_FEED];
			init_n_out <= dev_ctl_q[`PP_DC_INIT];
			select_in_n_out <= dev_ctl_q[`PP_DC_SELECT_IN];
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// undefined locations read as zero
	always @* begin
		case (addr_in)
		`PP_OFS_DATA: begin
			rdata_d = sync2_q[7:0];
		end
		`PP_OFS_LINE_STATUS: begin
			rdata_d = {!sync2_q[12], sync2_q[13], sync2_q[14],
				sync2_q[15], sync2_q[16], 3'b111};
		end
		`PP_OFS_DEVICE_CONTROL: begin
			// bits 7..5 fixed one, legacy enable fixed zero
			rdata_d = {3'b111, 1'b0, sync2_q[11], sync2_q[10],
				!sync2_q[9], !sync2_q[8]};
		end
		`PP_OFS_MODE_CONTROL: begin
			rdata_d = {mode_ctl_q, 3'b000};
		end
		`PP_OFS_IRQ_ENABLE: begin
			// request side lives with the interrupt logic
			rdata_d = 8'h00;
		end
		`PP_OFS_LEGACY_DELAY: begin
			rdata_d = legacy_delay_q;
		end
		`PP_OFS_PULSE_DELAY: begin
			rdata_d = pulse_delay_q;
		end
		default: begin
			rdata_d = 8'h00;
		end
		endcase
	end

	// read data held until the next read
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_en_in) begin
			rdata_out <= rdata_d;
		end
	end

endmodule

`default_nettype wire

// ===== verif/pp_port_slave_properties.sv
// assertions on the printer port slave host port and connector pins.
// assumes host writes at least two cycles apart, as the bench makes them.
`timescale 1ns/1ns
`default_nettype none

module pp_slave_chk (
	// clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// host byte port
	input wire [11:0] addr_in,
	input wire wr_en_in,
	input wire rd_en_in,
	input wire [7:0] wdata_in,
	input wire [7:0] rdata_out,
	input wire dma_busy_in,
	// connector lines
	input wire [7:0] data_line_in,
	input wire [7:0] data_line_out,
	input wire data_line_oe_out,
	input wire strobe_n_out,
	input wire auto_feed_n_out,
	input wire init_n_out,
	input wire select_in_n_out,
	input wire select_in_n_sense_in,
	input wire busy_in
);
	// -------------------------------------------------------------
	// one clock domain, async reset masks everything
	// -------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	chk_reset_lines:
	assert property ($rose(rst_n_in) |-> strobe_n_out && auto_feed_n_out
		&& !init_n_out && !select_in_n_out) else $error("reset pin levels");
	chk_status_fixed:
	assert property (rd_en_in && addr_in == 12'h801 |=> rdata_out[2:0] == 3'h7)
		else $error("status low bits");
	// busy must have settled through the synchroniser first
	chk_status_busy:
	assert property (rd_en_in && addr_in == 12'h801 && busy_in && $past(busy_in)
		&& $past(busy_in, 2) && $past(rst_n_in, 3) |=> !rdata_out[7])
		else $error("status busy bit");
	chk_ctl_fixed:
	assert property (rd_en_in && addr_in == 12'h802 |=> rdata_out[7:4] == 4'he)
		else $error("control fixed bits");
	chk_ctl_sense:
	assert property (rd_en_in && addr_in == 12'h802 && $stable(select_in_n_sense_in)
		&& $past(select_in_n_sense_in, 2) == select_in_n_sense_in
		|=> rdata_out[3] == $past(select_in_n_sense_in)) else $error("sense bit");
	chk_slin_follow:
	assert property (wr_en_in && addr_in == 12'h802 |-> ##3
		select_in_n_out == $past(wdata_in[3], 3)) else $error("select-in pin");
	chk_init_follow:
	assert property (wr_en_in && addr_in == 12'h802 |-> ##3
		init_n_out == $past(wdata_in[2], 3)) else $error("init pin");
	chk_feed_follow:
	assert property (wr_en_in && addr_in == 12'h802 |-> ##3
		auto_feed_n_out == !$past(wdata_in[1], 3)) else $error("auto-feed pin");
	chk_dirrst_keep:
	assert property ((!wr_en_in)[*3] ##1 wr_en_in && addr_in == 12'h000
		##1 (!wr_en_in)[*3] |-> {auto_feed_n_out, init_n_out, select_in_n_out}
		== $past({auto_feed_n_out, init_n_out, select_in_n_out}, 4))
		else $error("directed reset moved a line");
	chk_dma_ignore:
	assert property (wr_en_in && addr_in == 12'h800 && dma_busy_in |-> ##3
		data_line_out == $past(data_line_out, 3)) else $error("dma write taken");
	chk_unused_zero:
	assert property (rd_en_in && (addr_in == 12'h803 || addr_in == 12'h000)
		|=> rdata_out == 8'h00) else $error("unused read");
	chk_data_input:
	assert property (rd_en_in && addr_in == 12'h800 && !data_line_oe_out
		&& $stable(data_line_in) && $past(data_line_in) == $past(data_line_in, 2)
		|=> rdata_out == $past(data_line_in)) else $error("data read");
endmodule

bind pp_port_slave pp_slave_chk chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
	.wdata_in(wdata_in), .rdata_out(rdata_out), .dma_busy_in(dma_busy_in),
	.data_line_in(data_line_in), .data_line_out(data_line_out),
	.data_line_oe_out(data_line_oe_out), .strobe_n_out(strobe_n_out),
	.auto_feed_n_out(auto_feed_n_out), .init_n_out(init_n_out),
	.select_in_n_out(select_in_n_out), .busy_in(busy_in),
	.select_in_n_sense_in(select_in_n_sense_in));

`default_nettype wire

// ===== verif/pp_printer_model.sv
// behavioural printer: latches a byte on each strobe that falls while it is not busy, then busy and ack.
// assumes pull-ups on all lines, so a released data bus reads all ones.
`timescale 1ns/1ns
`default_nettype none

module pp_printer_model (
	// device side of the connector
	input wire logic [7:0] dev_data_in,
	input wire logic dev_oe_in,
	input wire logic strobe_n_in,
	// bench controls: forced status levels, reply byte, answer speed
	input wire logic [4:0] force_in,
	input wire logic [7:0] reply_in,
	input wire logic reply_en_in,
	input wire logic [15:0] busy_ns_in,
	// lines back to the device
	output wire logic [7:0] data_line_out,
	output var logic [7:0] last_byte_out,
	output wire logic busy_out,
	output wire logic ack_n_out,
	output wire logic paper_empty_out,
	output wire logic select_out,
	output wire logic fault_n_out
);
	logic busy_q = 1'b0; // busy while digesting a byte
	logic ack_q = 1'b1; // acknowledge, active low
	// device wins, else our reply, else the pull-ups
	assign data_line_out = dev_oe_in ? dev_data_in :
		(reply_en_in ? reply_in : 8'hff);
	// a slow answer stretches busy and ack alike
	always @(negedge strobe_n_in) begin
		last_byte_out = data_line_out;
		busy_q = 1'b1;
		#(busy_ns_in);
		ack_q = 1'b0;
		#(busy_ns_in);
		ack_q = 1'b1;
		busy_q = 1'b0;
	end
	assign busy_out = force_in[4] | busy_q;
	assign ack_n_out = ack_q & ~force_in[3];
	assign paper_empty_out = force_in[2];
	assign select_out = force_in[1];
	assign fault_n_out = ~force_in[0];
endmodule

`default_nettype wire

// ===== verif/printer_port_slave_registers_bench.sv
// self-checking bench for the printer port slave registers.
// assumes the printer model beside the block and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module printer_port_slave_registers_bench;
	// host side stimulus
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] addr = 12'h000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic dma = 1'b0;
	logic [7:0] wdata = 8'h00;
	// printer model controls
	logic [4:0] force_lines = 5'h00;
	logic reply_en = 1'b0;
	logic [15:0] busy_ns = 16'h0028;
	// observed lines; sense inputs see the driven pins directly
	wire [7:0] rdata, dl_in, dl_out, last_byte;
	wire oe, stb_n, afd_n, init_n, slin_n, busy, ack_n, pe, sel, fault_n;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] v;
	int n;

	pp_port_slave uut (.clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
		.wr_en_in(wr), .rd_en_in(rd), .wdata_in(wdata), .rdata_out(rdata),
		.dma_busy_in(dma), .data_line_in(dl_in), .data_line_out(dl_out),
		.data_line_oe_out(oe), .strobe_n_out(stb_n), .auto_feed_n_out(afd_n),
		.init_n_out(init_n), .select_in_n_out(slin_n),
		.strobe_n_sense_in(stb_n), .auto_feed_n_sense_in(afd_n),
		.init_n_sense_in(init_n), .select_in_n_sense_in(slin_n),
		.busy_in(busy), .ack_n_in(ack_n), .paper_empty_line_in(pe),
		.select_in(sel), .fault_n_in(fault_n));
	pp_printer_model printer (.dev_data_in(dl_out), .dev_oe_in(oe),
		.strobe_n_in(stb_n), .force_in(force_lines), .reply_in(8'h3c),
		.reply_en_in(reply_en), .busy_ns_in(busy_ns), .data_line_out(dl_in),
		.last_byte_out(last_byte), .busy_out(busy), .ack_n_out(ack_n),
		.paper_empty_out(pe), .select_out(sel), .fault_n_out(fault_n));

	// ---------------------------------------------------------------
	// clock, hang guard and shared tasks
	// ---------------------------------------------------------------
	initial begin
		forever #2 clk = ~clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one byte write; strobe drops a cycle later, never on an edge
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		d = rdata;
	endtask
	// long enough for pins and the input synchroniser
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic count_while(input logic lvl, output int cnt);
		cnt = 0;
		while (stb_n === lvl && cnt < 200) begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		check("pins", {3'h0, oe, stb_n, afd_n, init_n, slin_n}, 8'h1c);
		rd_reg(12'h807, v);
		check("pulse delay", v, 8'hfa);
		wr_reg(12'h806, 8'h5a);
		rd_reg(12'h806, v);
		check("legacy delay", v, 8'h5a);
		rd_reg(12'h802, v);
		check("control", v, 8'he0);
		rd_reg(12'h803, v);
		check("unused", v, 8'h00);
	endtask
	task automatic t_control();
		wr_reg(12'h802, 8'h3f);
		settle();
		check("pins", {3'h0, oe, stb_n, afd_n, init_n, slin_n}, 8'h13);
		rd_reg(12'h802, v);
		check("control", v, 8'hef);
		for (int m = 0; m < 8; m++) begin
			wr_reg(12'h802, 8'h00);
			wr_reg(12'h804, {m[2:0], 5'h00});
			wr_reg(12'h802, 8'h01);
			settle();
			check("strobe", {7'h00, stb_n}, (m == 1 || m == 2 || m == 4));
			rd_reg(12'h804, v);
			check("mode", v, {m[2:0], 5'h00});
		end
		wr_reg(12'h802, 8'h00);
	endtask
	task automatic t_status();
		// the last manual strobe still has the printer busy and acking
		repeat (40) @(posedge clk);
		#1;
		for (int k = 0; k < 4; k++) begin
			force_lines = {k[0], k[1], k[0], k[1], k[0]};
			wr_reg(12'h801, 8'h00);
			settle();
			rd_reg(12'h801, v);
			check("status", v, {~force_lines[4:3], force_lines[2:1],
				~force_lines[0], 3'h7});
		end
		force_lines = 5'h00;
	endtask
	task automatic t_data();
		wr_reg(12'h804, 8'h00);
		wr_reg(12'h800, 8'ha5);
		settle();
		check("data out", dl_out, 8'ha5);
		dma = 1'b1;
		wr_reg(12'h800, 8'h5a);
		settle();
		check("dma write", dl_out, 8'ha5);
		rd_reg(12'h800, v);
		check("dma read", v, 8'ha5);
		dma = 1'b0;
		wr_reg(12'h804, 8'h10);
		settle();
		check("oe out", {7'h00, oe}, 8'h01);
		reply_en = 1'b1;
		wr_reg(12'h802, 8'h20);
		settle();
		check("oe in", {7'h00, oe}, 8'h00);
		rd_reg(12'h800, v);
		check("data in", v, 8'h3c);
		wr_reg(12'h804, 8'h00);
		settle();
		check("oe bidir off", {7'h00, oe}, 8'h01);
		reply_en = 1'b0;
	endtask
	// busy-only mode, slow printer, short delay count
	task automatic t_auto();
		busy_ns = 16'h0190;
		wr_reg(12'h802, 8'h0e);
		wr_reg(12'h807, 8'h04);
		wr_reg(12'h804, 8'h40);
		wr_reg(12'h800, 8'h81);
		count_while(1'b1, n);
		count_while(1'b0, n);
		check("strobe width", n[7:0], 8'h04);
		check("printed", last_byte, 8'h81);
		check("pins", {4'h0, stb_n, afd_n, init_n, slin_n}, 8'h0b);
		// force bit: strobe falls while the printer is still busy
		wr_reg(12'h804, 8'h48);
		wr_reg(12'h800, 8'h42);
		count_while(1'b1, n);
		check("forced setup", n[7:0], 8'h05);
		count_while(1'b0, n);
		check("forced width", n[7:0], 8'h04);
	endtask
	task automatic t_dirrst();
		settle();
		wr_reg(12'h000, 8'h5a);
		settle();
		check("kept pins", {4'h0, stb_n, afd_n, init_n, slin_n}, 8'h0b);
		check("data reset", dl_out, 8'h00);
		rd_reg(12'h804, v);
		check("mode reset", v, 8'h00);
		rd_reg(12'h807, v);
		check("delay reset", v, 8'hfa);
		wr_reg(12'h802, 8'h00);
		settle();
		check("pins", {4'h0, stb_n, afd_n, init_n, slin_n}, 8'h0c);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_control();
		t_status();
		t_data();
		t_auto();
		t_dirrst();
		wrap_up();
	end
endmodule

`default_nettype wire
